// ===== core/dcd_pkg.sv
package dcd_pkg;
    // widths of the command/address pins
    localparam int BANK_W = 3;
    localparam int ADDR_W = 13;
    localparam int ROW_W = 13;
    localparam int COL_W = 11;
    localparam int NUM_BANKS = 8;
    // address bit positions
    localparam int AP_BIT = 10;
    localparam int BC_BIT = 12;
    localparam int ZQ_BIT = 10;
    localparam int COL_HI_BIT = 11;
    localparam int COL_LO_W = 10;
    // read latency window, ps and cycles at 100 MHz
    localparam int CLK_PERIOD_PS = 10000;
    localparam int TAA_MIN_PS = 13750;
    localparam int TAA_MAX_PS = 20000;
    localparam int TAA_MIN_CYC = (TAA_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TAA_MAX_CYC = (TAA_MAX_PS / CLK_PERIOD_PS) < 1 ? 1 : (TAA_MAX_PS / CLK_PERIOD_PS);
    localparam int BL8_BEATS = 8;
    localparam int BC4_BEATS = 4;
    localparam logic [3:0] BURST_CNT_ZERO = 4'h0;

    // decoded command codes
    typedef enum logic [3:0] {
        DCD_CMD_NONE = 4'h0,
        DCD_CMD_MRS = 4'h1,
        DCD_CMD_REF = 4'h2,
        DCD_CMD_SRE = 4'h3,
        DCD_CMD_SRX = 4'h4,
        DCD_CMD_PRE = 4'h5,
        DCD_CMD_PREA = 4'h6,
        DCD_CMD_ACT = 4'h7,
        DCD_CMD_WR = 4'h8,
        DCD_CMD_RD = 4'h9,
        DCD_CMD_PDE = 4'hA,
        DCD_CMD_PDX = 4'hB,
        DCD_CMD_ZQCL = 4'hC,
        DCD_CMD_ZQCS = 4'hD,
        DCD_CMD_ILLEGAL = 4'hE
    } dcd_cmd_t;

    // device power state, gray along idle->pd->idle and idle->sr->idle
    typedef enum logic [1:0] {
        DCD_ST_ACTIVE = 2'b00,
        DCD_ST_PD = 2'b01,
        DCD_ST_SR = 2'b10
    } dcd_state_t;

    // pins sampled on one clock edge
    typedef struct packed {
        logic cke;
        logic cs_b;
        logic ras_b;
        logic cas_b;
        logic we_b;
        logic [BANK_W-1:0] ba;
        logic [ADDR_W-1:0] addr;
    } dcd_pins_t;

    // decoded command toward the core
    typedef struct packed {
        dcd_cmd_t cmd;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] operand;
        logic auto_pre;
        logic bl8;
    } dcd_cmd_out_t;
endpackage

// ===== core/dcd_burst_timer.sv
`timescale 1ns/100ps
// counts the read latency then the burst beats; new reads are not taken while busy
module dcd_burst_timer
    import dcd_pkg::*;
#(
    parameter int LAT_CYC = TAA_MIN_CYC
) (
    input wire logic clock, // core clock
    input wire logic rst_b, // async reset, active low
    input wire logic start, // read accepted
    input wire logic bl8, // eight beats, else four
    output logic busy, // latency or burst running
    output logic data_valid // read data beat window
);
    import dcd_pkg::*;
    logic [3:0] lat_q;
    logic [3:0] beats_q;

    // latency then beats; a burst always runs to its end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            lat_q <= BURST_CNT_ZERO;
            beats_q <= BURST_CNT_ZERO;
        end else if (start && !busy) begin
            lat_q <= 4'(LAT_CYC);
            beats_q <= bl8 ? 4'(BL8_BEATS) : 4'(BC4_BEATS);
        end else if (lat_q != BURST_CNT_ZERO) begin
            lat_q <= lat_q - 4'h1;
        end else if (beats_q != BURST_CNT_ZERO) begin
            beats_q <= beats_q - 4'h1;
        end
    end

    // registered outputs
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            busy <= 1'b0;
            data_valid <= 1'b0;
        end else begin
            busy <= (start && !busy) || lat_q > 4'h1 || beats_q > 4'h1
                || (lat_q != BURST_CNT_ZERO && beats_q != BURST_CNT_ZERO);
            data_valid <= (lat_q == 4'h1) || (lat_q == BURST_CNT_ZERO && beats_q > 4'h1);
        end
    end
endmodule

// ===== core/dcd_decoder.sv
`timescale 1ns/100ps
module dcd_decoder
    import dcd_pkg::*;
#(
    parameter int READ_LAT_CYC = TAA_MIN_CYC
) (
    input wire logic clock, // command clock
    input wire logic rst_b, // async reset pin, active low
    input wire dcd_pkg::dcd_pins_t pins, // command and address pins
    input wire logic odt_pin, // termination request pin
    input wire logic otf_mode, // burst size picked per command
    input wire logic fixed_bl8, // fixed burst size is eight
    output dcd_pkg::dcd_cmd_out_t cmd_out, // decoded command
    output logic cmd_valid, // one-cycle command strobe
    output logic [BANK_W-1:0] mr_select, // last mode register written
    output logic [ADDR_W-1:0] mr_opcode, // last mode register opcode
    output logic [NUM_BANKS-1:0] bank_open, // banks with an open row
    output dcd_pkg::dcd_state_t pwr_state, // power state
    output logic refresh_enable, // internal refresh allowed
    output logic odt_enable, // termination active
    output logic read_data_valid, // read data beat window
    output logic read_busy // read burst in progress
);
    import dcd_pkg::*;

    dcd_pins_t s1_q;
    dcd_pins_t s2_q;
    logic cke_prev_q;
    logic [1:0] fill_q;
    logic odt_s1_q;
    logic odt_s2_q;
    logic sr_cke_q;
    logic sr_exit_s1_q;
    logic sr_exit_s2_q;
    dcd_cmd_t cmd_d;
    logic bl8_d;
    logic burst_busy;
    logic burst_dv;

    // two-flop synchronisers on every pin before decode
    // reset is the pin's only job: it clears every flop and never decodes as a command
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s1_q <= '0;
            s2_q <= '0;
            odt_s1_q <= 1'b0;
            odt_s2_q <= 1'b0;
        end else begin
            s1_q <= pins;
            s2_q <= s1_q;
            odt_s1_q <= odt_pin;
            odt_s2_q <= odt_s1_q;
        end
    end

    // wait until both synchroniser stages and cke_prev_q hold real samples;
    // the reset contents would otherwise decode as a power-down exit
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            fill_q <= 2'h0;
        end else if (fill_q != 2'h3) begin
            fill_q <= fill_q + 2'h1;
        end
    end

    // previous CKE sample, for the transition columns
    // reset value low: the first real sample looks like a rise, masked by fill_q
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cke_prev_q <= 1'b0;
        end else begin
            cke_prev_q <= s2_q.cke;
        end
    end

    // self-refresh exit: catch the CKE rise without a clock, the pin edge itself sets the flag
    // the clock may be stopped here, so this flop must not depend on it
    // limitation: a glitch on CKE during self refresh sets the exit flag; exit still needs CKE sampled high
    always_ff @(posedge pins.cke or negedge rst_b) begin
        if (!rst_b) begin
            sr_cke_q <= 1'b0;
        end else begin
            sr_cke_q <= (pwr_state == DCD_ST_SR);
        end
    end

    // bring the asynchronous exit flag into the clock domain
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sr_exit_s1_q <= 1'b0;
            sr_exit_s2_q <= 1'b0;
        end else begin
            sr_exit_s1_q <= sr_cke_q;
            sr_exit_s2_q <= sr_exit_s1_q;
        end
    end

    // command decode from the sampled pins
    always_comb begin
        cmd_d = DCD_CMD_NONE;
        if (fill_q != 2'h3) begin
            cmd_d = DCD_CMD_NONE;
        end else if (pwr_state == DCD_ST_SR) begin
            // pins are don't-care until CKE comes back
            cmd_d = (s2_q.cke && (sr_exit_s2_q || !cke_prev_q)) ? DCD_CMD_SRX : DCD_CMD_NONE;
        end else if (cke_prev_q && !s2_q.cke) begin
            if (s2_q.cs_b || {s2_q.ras_b, s2_q.cas_b, s2_q.we_b} == 3'b111) begin
                cmd_d = DCD_CMD_PDE;
            end else if ({s2_q.ras_b, s2_q.cas_b, s2_q.we_b} == 3'b001) begin
                cmd_d = DCD_CMD_SRE;
            end else begin
                cmd_d = DCD_CMD_ILLEGAL;
            end
        end else if (!cke_prev_q && s2_q.cke) begin
            if (s2_q.cs_b || {s2_q.ras_b, s2_q.cas_b, s2_q.we_b} == 3'b111) begin
                cmd_d = DCD_CMD_PDX;
            end else begin
                cmd_d = DCD_CMD_ILLEGAL;
            end
        end else if (cke_prev_q && s2_q.cke && !s2_q.cs_b) begin
            unique case ({s2_q.ras_b, s2_q.cas_b, s2_q.we_b})
                3'b000: cmd_d = DCD_CMD_MRS;
                3'b001: cmd_d = DCD_CMD_REF;
                3'b010: cmd_d = s2_q.addr[AP_BIT] ? DCD_CMD_PREA : DCD_CMD_PRE;
                3'b011: cmd_d = DCD_CMD_ACT;
                3'b100: cmd_d = DCD_CMD_WR;
                3'b101: cmd_d = DCD_CMD_RD;
                3'b110: cmd_d = s2_q.addr[ZQ_BIT] ? DCD_CMD_ZQCL : DCD_CMD_ZQCS;
                3'b111: cmd_d = DCD_CMD_NONE;
            endcase
        end
        // cs_b high with CKE steady falls through as no-op, other pins unread
    end

    // burst size: A12 only matters in on-the-fly mode
    // in fixed mode A12 must still be a defined level; it is simply not read
    assign bl8_d = otf_mode ? s2_q.addr[BC_BIT] : fixed_bl8;

    // one-cycle strobe per decoded command; no-op and deselect give none
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cmd_valid <= 1'b0;
        end else begin
            cmd_valid <= (cmd_d != DCD_CMD_NONE);
        end
    end

    // registered decoded command
    // operand keeps the raw address for activate and mode register commands
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cmd_out <= '0;
        end else begin
            cmd_out.cmd <= cmd_d;
            cmd_out.bank <= s2_q.ba;
            cmd_out.auto_pre <= (cmd_d == DCD_CMD_RD || cmd_d == DCD_CMD_WR) && s2_q.addr[AP_BIT];
            cmd_out.bl8 <= bl8_d;
            if (cmd_d == DCD_CMD_RD || cmd_d == DCD_CMD_WR) begin
                // column sits on A0-A9 and A11
                cmd_out.operand <= {{(ADDR_W-COL_W){1'b0}}, s2_q.addr[COL_HI_BIT],
                    s2_q.addr[COL_LO_W-1:0]};
            end else begin
                cmd_out.operand <= s2_q.addr;
            end
        end
    end

    // mode register set: bank pins choose the register
    // cmd_out carries the opcode too; this copy holds it between commands
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            mr_select <= '0;
            mr_opcode <= '0;
        end else if (cmd_d == DCD_CMD_MRS) begin
            mr_select <= s2_q.ba;
            mr_opcode <= s2_q.addr;
        end
    end

    // open-row tracking, one flop per bank
    for (genvar gb = 0; gb < NUM_BANKS; gb++) begin : g_bank
        logic hit;
        assign hit = (s2_q.ba == BANK_W'(gb));
        always_ff @(posedge clock or negedge rst_b) begin
            if (!rst_b) begin
                bank_open[gb] <= 1'b0;
            end else if (cmd_d == DCD_CMD_ACT && hit) begin
                bank_open[gb] <= 1'b1;
            end else if (cmd_d == DCD_CMD_PREA) begin
                bank_open[gb] <= 1'b0;
            end else if (hit && (cmd_d == DCD_CMD_PRE || ((cmd_d == DCD_CMD_RD || cmd_d == DCD_CMD_WR)
                && s2_q.addr[AP_BIT]))) begin
                // auto precharge closes once the burst is done; tracked as closed from here
                bank_open[gb] <= 1'b0;
            end
        end
    end

    // power state machine
    // illegal CKE-edge patterns leave the power state alone
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pwr_state <= DCD_ST_ACTIVE;
        end else begin
            unique case (pwr_state)
                DCD_ST_ACTIVE: begin
                    if (cmd_d == DCD_CMD_PDE) begin
                        pwr_state <= DCD_ST_PD;
                    end else if (cmd_d == DCD_CMD_SRE) begin
                        pwr_state <= DCD_ST_SR;
                    end
                end
                DCD_ST_PD: begin
                    if (cmd_d == DCD_CMD_PDX) begin
                        pwr_state <= DCD_ST_ACTIVE;
                    end
                end
                DCD_ST_SR: begin
                    if (cmd_d == DCD_CMD_SRX) begin
                        pwr_state <= DCD_ST_ACTIVE;
                    end
                end
                default: pwr_state <= DCD_ST_ACTIVE;
            endcase
        end
    end

    // refresh only outside power-down; lags the state by one cycle
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            refresh_enable <= 1'b0;
        end else begin
            refresh_enable <= (pwr_state != DCD_ST_PD);
        end
    end

    // termination never in self refresh; odt level only gates termination, never decode
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            odt_enable <= 1'b0;
        end else begin
            odt_enable <= odt_s2_q && (pwr_state != DCD_ST_SR) && (cmd_d != DCD_CMD_SRE);
        end
    end

    // read latency and burst; later commands cannot cut it short
    // the timer refuses a second read until the first burst has drained
    dcd_burst_timer #(
        .LAT_CYC(READ_LAT_CYC)
    ) u_burst (
        .clock(clock),
        .rst_b(rst_b),
        .start(cmd_d == DCD_CMD_RD),
        .bl8(bl8_d),
        .busy(burst_busy),
        .data_valid(burst_dv)
    );

    // registered copies of the burst status
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            read_data_valid <= 1'b0;
            read_busy <= 1'b0;
        end else begin
            read_data_valid <= burst_dv;
            read_busy <= burst_busy;
        end
    end
endmodule

// ===== verif/dcd_decoder_props.sv
`timescale 1ns/100ps
// port watcher; a command sampled at one edge is decoded three edges later
module dcd_decoder_props (
    input wire logic clock, // command clock
    input wire logic rst_b, // async reset, active low
    input wire dcd_pkg::dcd_pins_t pins, // command pins
    input wire logic otf_mode, // burst size per command
    input wire logic fixed_bl8, // fixed burst size
    input wire dcd_pkg::dcd_cmd_out_t cmd_out, // decoded command
    input wire logic cmd_valid, // command strobe
    input wire logic [dcd_pkg::BANK_W-1:0] mr_select, // last mode register
    input wire dcd_pkg::dcd_state_t pwr_state, // power state
    input wire logic refresh_enable, // refresh allowed
    input wire logic odt_enable, // termination on
    input wire logic read_data_valid, // read beats
    input wire logic read_busy // read running
);
    import dcd_pkg::*;
    logic cke_q;
    logic [2:0] up_q;
    // up_q masks early edges whose pin history predates reset
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cke_q <= 1'b0;
            up_q <= 3'h0;
        end else begin
            cke_q <= pins.cke;
            if (up_q != 3'h7) up_q <= up_q + 3'h1;
        end
    end
    // command classes on the current sample
    wire logic [3:0] ctl = {pins.cs_b, pins.ras_b, pins.cas_b, pins.we_b};
    wire logic live = (up_q == 3'h7) && (pwr_state == DCD_ST_ACTIVE);
    wire logic steady = live && pins.cke && cke_q;
    wire logic rdwr = steady && (ctl[3:1] == 3'h2);
    wire logic idle = pins.cs_b || (ctl == 4'h7);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    a_read_decode: assert property (rdwr && pins.we_b |-> ##3 cmd_valid && cmd_out.cmd == DCD_CMD_RD)
        else $error("read not decoded");
    a_write_decode: assert property (rdwr && !pins.we_b |-> ##3 cmd_valid && cmd_out.cmd == DCD_CMD_WR)
        else $error("write not decoded");
    a_col_bank: assert property (rdwr |-> ##3 cmd_out.bank == $past(pins.ba, 3)
        && cmd_out.operand[COL_W-1:0] == {$past(pins.addr[COL_HI_BIT], 3), $past(pins.addr[COL_LO_W-1:0], 3)})
        else $error("bank or column wrong");
    a_auto_pre: assert property (rdwr |-> ##3 cmd_out.auto_pre == $past(pins.addr[AP_BIT], 3))
        else $error("auto precharge flag wrong");
    a_burst_pick: assert property (rdwr |-> ##3 cmd_out.bl8 == $past(otf_mode ? pins.addr[BC_BIT] : fixed_bl8, 3))
        else $error("burst size wrong");
    a_nop_quiet: assert property (steady && idle |-> ##3 !cmd_valid)
        else $error("no-op produced a command");
    a_mrs_target: assert property (steady && ctl == 4'h0 |-> ##5 mr_select == $past(pins.ba, 5))
        else $error("mode register select wrong");
    a_pd_enter: assert property (live && cke_q && !pins.cke && idle |-> ##[3:4] pwr_state == DCD_ST_PD)
        else $error("power-down not entered");
    a_sr_enter: assert property (live && cke_q && !pins.cke && ctl == 4'h1 |-> ##[3:4] pwr_state == DCD_ST_SR)
        else $error("self refresh not entered");
    a_sr_exit: assert property (pwr_state == DCD_ST_SR && $rose(pins.cke) |-> ##[1:5] pwr_state == DCD_ST_ACTIVE)
        else $error("self refresh not left");
    a_pd_norefresh: assert property (pwr_state == DCD_ST_PD && $past(pwr_state) == DCD_ST_PD |-> !refresh_enable)
        else $error("refresh during power-down");
    a_sr_no_odt: assert property (pwr_state == DCD_ST_SR && $past(pwr_state) == DCD_ST_SR |-> !odt_enable)
        else $error("termination on in self refresh");
    a_read_lat: assert property ($rose(read_busy) |-> ##2 $rose(read_data_valid))
        else $error("read latency wrong");
    a_burst_len: assert property ($rose(read_data_valid) |-> read_data_valid[*4] ##1
        (!read_data_valid or read_data_valid[*4] ##1 !read_data_valid))
        else $error("burst length wrong");
    c_read: cover property (rdwr && pins.we_b);
    c_sr: cover property (pwr_state == DCD_ST_SR);
    c_pd: cover property (pwr_state == DCD_ST_PD);
endmodule

// ===== verif/dcd_ctrl_model.sv
`timescale 1ns/100ps
// controller stand-in: issue drives pins at the falling edge, set_cke moves CKE at once; idles on no-ops
module dcd_ctrl_model (
    input wire logic clock, // command clock
    output dcd_pkg::dcd_pins_t pins // command and address pins
);
    import dcd_pkg::*;
    localparam int TCK_NS = 10;
    // power-up idle is a no-op with clock enable high
    initial pins = {1'b1, 4'h7, 3'h0, 13'h0};
    // one command then no-ops; callers keep activates 50 ns apart
    task automatic issue(input logic ck, input logic [3:0] c, input logic [2:0] b, input logic [12:0] a,
        input int gap);
        @(negedge clock);
        pins = {ck, c, b, a};
        @(negedge clock);
        pins = {ck, 4'h7, 3'h0, 13'h0};
        repeat (gap) @(negedge clock);
    endtask
    // clock enable may move while the clock is stopped
    task automatic set_cke(input logic v);
        pins.cke = v;
    endtask
    // only no-ops until the write hold-off after self refresh has run out
    task automatic sr_recover();
        repeat (512) @(negedge clock);
    endtask
endmodule

// ===== verif/tb.sv
`timescale 1ns/100ps
module tb;
    import dcd_pkg::*;
    logic clock;
    logic clk_en;
    logic rst_b;
    logic odt_pin;
    logic otf_mode;
    logic fixed_bl8;
    dcd_pins_t pins;
    dcd_cmd_out_t cmd_out;
    dcd_cmd_out_t last_q;
    dcd_state_t pwr_state;
    logic cmd_valid;
    logic [BANK_W-1:0] mr_select;
    logic [ADDR_W-1:0] mr_opcode;
    logic [NUM_BANKS-1:0] bank_open;
    logic refresh_enable;
    logic odt_enable;
    logic read_data_valid;
    logic read_busy;
    int n_errors;
    int compares;
    int beats;
    int n_cmd;
    dcd_ctrl_model m (.clock(clock), .pins(pins));
    dcd_decoder dut (.clock(clock), .rst_b(rst_b), .pins(pins), .odt_pin(odt_pin), .otf_mode(otf_mode),
        .fixed_bl8(fixed_bl8), .cmd_out(cmd_out), .cmd_valid(cmd_valid), .mr_select(mr_select),
        .mr_opcode(mr_opcode), .bank_open(bank_open), .pwr_state(pwr_state), .refresh_enable(refresh_enable),
        .odt_enable(odt_enable), .read_data_valid(read_data_valid), .read_busy(read_busy));
    // clock stops low when clk_en drops, as in self refresh
    initial begin
        clock = 1'b0;
        forever #5 clock = clk_en ? ~clock : 1'b0;
    end
    // keep the last decoded command and count read beats
    always @(posedge clock) begin
        if (cmd_valid === 1'b1) begin
            last_q <= cmd_out;
            n_cmd <= n_cmd + 1;
        end
        if (read_data_valid === 1'b1) beats <= beats + 1;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("compares=%0d errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // bounded wait for a power state; running out counts as a mismatch
    task automatic wait_state(input dcd_state_t s);
        int k;
        k = 0;
        while (pwr_state !== s && k < 20) begin
            @(negedge clock);
            k++;
        end
        chk(pwr_state, s);
        if (k == 20) close_out();
    endtask
    // all burst-size, precharge and direction mixes on one bank
    task automatic t_rdwr();
        logic [3:0] i;
        logic e8;
        for (int k = 0; k < 16; k++) begin
            i = k[3:0];
            otf_mode = i[0];
            fixed_bl8 = !i[1];
            e8 = i[0] ? i[1] : !i[1];
            m.issue(1'b1, 4'h3, 3'h5, 13'h00ab, 5);
            chk(bank_open[5], 1'b1);
            beats = 0;
            m.issue(1'b1, {3'h2, i[3]}, 3'h5, {i[1], 1'b1, i[2], 10'h2aa}, 14);
            chk(last_q.cmd, i[3] ? DCD_CMD_RD : DCD_CMD_WR);
            chk(last_q.bank, 3'h5);
            chk(last_q.operand, 13'h06aa);
            chk(last_q.auto_pre, i[2]);
            chk(last_q.bl8, e8);
            chk(bank_open[5], !i[2]);
            if (i[3]) chk(beats, e8 ? 8 : 4);
            m.issue(1'b1, 4'h2, 3'h5, 13'h0000, 5);
            chk(last_q.cmd, DCD_CMD_PRE);
            chk(bank_open[5], 1'b0);
        end
        $display("t_rdwr done");
    endtask
    // mode register writes pick the register by bank pins
    task automatic t_mrs();
        for (int b = 0; b < 4; b++) begin
            m.issue(1'b1, 4'h0, b[2:0], {b[2:0], 10'h155}, 5);
            chk(last_q.cmd, DCD_CMD_MRS);
            chk(mr_select, b[2:0]);
            chk(mr_opcode, {b[2:0], 10'h155});
        end
        $display("t_mrs done");
    endtask
    // table of remaining steady-clock-enable commands
    task automatic t_table();
        logic [3:0] c [4] = '{4'h6, 4'h6, 4'h2, 4'h1};
        logic a [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        dcd_cmd_t e [4] = '{DCD_CMD_ZQCL, DCD_CMD_ZQCS, DCD_CMD_PREA, DCD_CMD_REF};
        for (int k = 0; k < 4; k++) begin
            m.issue(1'b1, c[k], 3'h0, {2'h0, a[k], 10'h000}, 5);
            chk(last_q.cmd, e[k]);
        end
        $display("t_table done");
    endtask
    // no-op, read-shaped deselect and a second read inside a burst
    task automatic t_nop();
        int n0;
        otf_mode = 1'b1;
        beats = 0;
        n0 = n_cmd;
        m.issue(1'b1, 4'h5, 3'h1, 13'h1000, 1);
        m.issue(1'b1, 4'hd, 3'h1, 13'h0000, 1);
        m.issue(1'b1, 4'h5, 3'h1, 13'h0000, 14);
        chk(beats, 8);
        chk(n_cmd - n0, 2);
        $display("t_nop done");
    endtask
    // power-down in and out, then self refresh with the clock stopped
    task automatic t_power();
        m.issue(1'b0, 4'h7, 3'h0, 13'h0000, 2);
        wait_state(DCD_ST_PD);
        @(negedge clock);
        chk(refresh_enable, 1'b0);
        m.issue(1'b1, 4'hf, 3'h0, 13'h0000, 2);
        wait_state(DCD_ST_ACTIVE);
        @(negedge clock);
        chk(refresh_enable, 1'b1);
        odt_pin = 1'b1;
        m.issue(1'b1, 4'h2, 3'h0, 13'h0400, 5);
        m.issue(1'b0, 4'h1, 3'h0, 13'h0000, 3);
        wait_state(DCD_ST_SR);
        chk(odt_enable, 1'b0);
        m.issue(1'b0, 4'h0, 3'h7, 13'h1fff, 3);
        chk(mr_select, 3'h3);
        clk_en = 1'b0;
        #50 m.set_cke(1'b1);
        #50 clk_en = 1'b1;
        wait_state(DCD_ST_ACTIVE);
        m.sr_recover();
        chk(odt_enable, 1'b1);
        m.issue(1'b1, 4'h4, 3'h2, 13'h0000, 5);
        chk(last_q.cmd, DCD_CMD_WR);
        $display("t_power done");
    endtask
    // reset in mid-run clears banks and state
    task automatic t_rst();
        m.issue(1'b1, 4'h3, 3'h6, 13'h0000, 5);
        rst_b = 1'b0;
        @(negedge clock);
        chk(bank_open, 8'h00);
        chk(cmd_valid, 1'b0);
        chk(pwr_state, DCD_ST_ACTIVE);
        rst_b = 1'b1;
        repeat (4) @(negedge clock);
        $display("t_rst done");
    endtask
    initial begin
        clk_en = 1'b1;
        rst_b = 1'b0;
        odt_pin = 1'b0;
        otf_mode = 1'b0;
        fixed_bl8 = 1'b1;
        n_errors = 0;
        compares = 0;
        beats = 0;
        n_cmd = 0;
        repeat (5) @(negedge clock);
        rst_b = 1'b1;
        repeat (4) @(negedge clock);
        t_rdwr();
        t_mrs();
        t_table();
        t_nop();
        t_power();
        t_rst();
        close_out();
    end
    // watchdog against a hang
    initial begin
        #900000;
        n_errors++;
        close_out();
    end
endmodule
bind dcd_decoder dcd_decoder_props chk_i (.clock, .rst_b, .pins, .otf_mode, .fixed_bl8, .cmd_out, .cmd_valid,
    .mr_select, .pwr_state, .refresh_enable, .odt_enable, .read_data_valid, .read_busy);
